/* hdl/axi_hs_pkg.sv */
/*
 Shared constants and types for the subordinate channel handshake block.
 Assumes a single 50 MHz clock; no registers reachable by software.
*/
package axi_hs_pkg;
    localparam int ID_W_DEF      = 4;
    localparam int ADDR_W_DEF    = 32;
    localparam int DATA_W_DEF    = 32;
    localparam int LEN_W         = 8;
    localparam int CNT_W         = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    // storage depth of the small memory; outstanding bursts are limited by the CNT_W counter
    localparam int MEM_WORDS_DEF = 16;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_BEAT = 3'b010,
        RD_HOLD = 3'b100
    } rd_state_t;
endpackage

/* hdl/hs_counter.sv */
/*
 Up/down occupancy counter used to track accepted but unanswered work.
 Assumes increment and decrement are single-cycle pulses in the i_clk domain.
*/
`timescale 1ns/100ps
module hs_counter #(
    parameter int W = 4
) (
    input  wire logic         i_clk,   // system clock
    input  wire logic         i_srst,  // synchronous reset, active high
    input  wire logic         i_inc,   // add one
    input  wire logic         i_dec,   // take one
    output logic [W-1:0]      o_count, // current count
    output logic              o_full,  // count at maximum
    output logic              o_zero   // count is zero
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } cnt_state_t;

    cnt_state_t st_ff;
    cnt_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (i_inc && !i_dec) begin
            nxt_st.cnt = st_ff.cnt + W'(1);
        end else if (i_dec && !i_inc) begin
            nxt_st.cnt = st_ff.cnt - W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_count = st_ff.cnt;
    assign o_full  = &st_ff.cnt;
    assign o_zero  = (st_ff.cnt == '0);
endmodule // hs_counter

/* hdl/axi_sub_handshake.sv */
/*
 Subordinate end of a five-channel valid/ready memory port: accepts write
 addresses and data in any order, answers writes after the last beat, and
 returns read bursts only for accepted read addresses.
 Assumes the requester keeps its own handshake duties; one clock, sync reset.
*/
`timescale 1ns/100ps
// Summary of operation
// RULE1: data moves only on an edge where valid and ready are both high
// RULE2: every output comes straight from a flip-flop, no input-to-output paths; o_bresp and o_rresp are tied to RESP_OKAY
// RULE3: a sender raises valid without waiting for ready
// RULE4: once raised, valid stays high until the handshake edge
// RULE5: payload stays unchanged while valid waits for ready
// RULE6: a receiver may wait for valid before raising ready, or raise it early
// RULE7: ready raised early may drop again before valid appears
// RULE8: five independent valid/ready pairs, one per channel
// RULE9: requester holds write-address valid until accepted
// RULE10: write-address ready idles high; when high any address is taken
// RULE11: requester holds write-data valid until accepted
// RULE12: write-data ready idles high only if a beat is always taken at once
// RULE13: requester marks the final write beat with last
// RULE14: response valid held with a valid response until response ready
// RULE15: requester may idle response ready high only if always able
// RULE16: requester holds read-address valid until accepted
// RULE17: read-address ready idles high; when high any address is taken
// RULE18: read valid only with real data for an accepted request, held till ready
// RULE19: requester may idle read ready high only if always able
// RULE20: read last marks the final beat of each read burst only
// RULE21: write response only after the last write beat is transferred
// RULE22: read data only after its read address is transferred
// RULE23: write data may come before or with its address
// RULE24: requester holds its valids low in reset
// RULE25: read valid and response valid are low during reset
// RULE26: inputs sampled on the rising edge, outputs change after it
// RULE27: no read valid before the read address handshake
// RULE28: count accepted addresses and bursts so only real work is answered
module axi_sub_handshake
    import axi_hs_pkg::*;
#(
    parameter int ID_W      = axi_hs_pkg::ID_W_DEF,
    parameter int ADDR_W    = axi_hs_pkg::ADDR_W_DEF,
    parameter int DATA_W    = axi_hs_pkg::DATA_W_DEF,
    parameter int MEM_WORDS = axi_hs_pkg::MEM_WORDS_DEF
) (
    input  wire logic                      i_clk,     // 50 MHz clock
    input  wire logic                      i_srst,    // sync reset, active high
    input  wire logic [ID_W-1:0]           i_awid,    // write id
    input  wire logic [ADDR_W-1:0]         i_awaddr,  // write address
    input  wire logic [axi_hs_pkg::LEN_W-1:0] i_awlen, // write beats minus one
    input  wire logic                      i_awvalid, // write address valid
    output logic                           o_awready, // write address ready
    input  wire logic [DATA_W-1:0]         i_wdata,   // write data
    input  wire logic [DATA_W/8-1:0]       i_wstrb,   // write byte strobes
    input  wire logic                      i_wlast,   // final write beat
    input  wire logic                      i_wvalid,  // write data valid
    output logic                           o_wready,  // write data ready
    output logic [ID_W-1:0]                o_bid,     // response id
    output logic [1:0]                     o_bresp,   // response code
    output logic                           o_bvalid,  // response valid
    input  wire logic                      i_bready,  // response ready
    input  wire logic [ID_W-1:0]           i_arid,    // read id
    input  wire logic [ADDR_W-1:0]         i_araddr,  // read address
    input  wire logic [axi_hs_pkg::LEN_W-1:0] i_arlen, // read beats minus one
    input  wire logic                      i_arvalid, // read address valid
    output logic                           o_arready, // read address ready
    output logic [ID_W-1:0]                o_rid,     // read id
    output logic [DATA_W-1:0]              o_rdata,   // read data
    output logic [1:0]                     o_rresp,   // read response
    output logic                           o_rlast,   // final read beat
    output logic                           o_rvalid,  // read data valid
    input  wire logic                      i_rready   // read data ready
);
    localparam int AW = $clog2(MEM_WORDS);

    // write addresses and data are decoupled by a one-entry address hold and
    // a one-beat data buffer; a burst's beats land at its address + beat index
    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 aw_held;
        logic [ID_W-1:0]      aw_id;
        logic [AW-1:0]        aw_ptr;
        logic                 wbuf_v;
        logic [DATA_W-1:0]    wbuf_d;
        logic [DATA_W/8-1:0]  wbuf_s;
        logic                 wbuf_last;
        logic                 bvalid;
        logic [ID_W-1:0]      bid;
        logic                 arready;
        rd_state_t            rd;
        logic [ID_W-1:0]      rid;
        logic [AW-1:0]        rptr;
        logic [LEN_W-1:0]     rleft;
        logic                 rvalid;
        logic                 rlast;
        logic [DATA_W-1:0]    rdata;
    } sub_state_t;

    sub_state_t              st_ff;
    sub_state_t              nxt_st;
    logic [DATA_W-1:0]       mem_ff [MEM_WORDS];
    logic                    aw_fire;
    logic                    w_fire;
    logic                    b_fire;
    logic                    ar_fire;
    logic                    r_fire;
    logic                    commit;
    logic                    burst_done;
    logic                    burst_full;
    logic [CNT_W-1:0]        open_bursts;

    assign aw_fire = i_awvalid && st_ff.awready;  // RULE1
    assign w_fire  = i_wvalid && st_ff.wready;    // RULE1
    assign b_fire  = st_ff.bvalid && i_bready;    // RULE1
    assign ar_fire = i_arvalid && st_ff.arready;  // RULE1
    assign r_fire  = st_ff.rvalid && i_rready;    // RULE1
    // a buffered beat commits once its burst address is known
    assign commit     = st_ff.wbuf_v && st_ff.aw_held;  // RULE23
    assign burst_done = commit && st_ff.wbuf_last;      // RULE21

    // bursts whose data finished but whose response is not yet taken
    hs_counter #(
        .W(CNT_W)
    ) u_bcount (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_inc   (burst_done),
        .i_dec   (b_fire),
        .o_count (open_bursts),
        .o_full  (burst_full),
        .o_zero  ()
    ); // RULE28

    always_comb begin
        nxt_st = st_ff;
        // address acceptance; ready idles high while the hold is free and the burst count is not full
        if (aw_fire) begin
            nxt_st.aw_held = 1'b1;  // RULE10
            nxt_st.aw_id   = i_awid;
            nxt_st.aw_ptr  = i_awaddr[AW+1:2];
        end
        if (burst_done) begin
            nxt_st.aw_held = 1'b0;  // RULE28
        end
        if (commit) begin
            nxt_st.aw_ptr = st_ff.aw_ptr + AW'(1);
            nxt_st.wbuf_v = 1'b0;
        end
        // data beats may arrive before the address; one beat is parked
        if (w_fire) begin
            nxt_st.wbuf_v    = 1'b1;  // RULE23
            nxt_st.wbuf_d    = i_wdata;
            nxt_st.wbuf_s    = i_wstrb;
            nxt_st.wbuf_last = i_wlast;  // RULE13
        end
        nxt_st.awready = !nxt_st.aw_held && !burst_full;  // RULE10 RULE7
        nxt_st.wready  = !nxt_st.wbuf_v;                  // RULE12 RULE6
        // response path: raised from state, never from i_bready
        if (b_fire) begin
            nxt_st.bvalid = 1'b0;  // RULE14
        end
        if (!nxt_st.bvalid && (open_bursts != '0) && !b_fire) begin
            nxt_st.bvalid = 1'b1;  // RULE21 RULE3
        end
        if (burst_done && !st_ff.bvalid) begin
            nxt_st.bid = st_ff.aw_id;
        end
        // read path
        case (st_ff.rd)
            RD_IDLE: begin
                nxt_st.arready = 1'b1;  // RULE17
                if (ar_fire) begin
                    nxt_st.arready = 1'b0;
                    nxt_st.rid     = i_arid;
                    nxt_st.rptr    = i_araddr[AW+1:2];
                    nxt_st.rleft   = i_arlen;
                    nxt_st.rd      = RD_BEAT;  // RULE22 RULE27
                end
            end
            RD_BEAT: begin
                nxt_st.rvalid = 1'b1;  // RULE18
                nxt_st.rdata  = mem_ff[st_ff.rptr];
                nxt_st.rlast  = (st_ff.rleft == '0);  // RULE20
                nxt_st.rd     = RD_HOLD;
            end
            RD_HOLD: begin
                if (r_fire) begin  // RULE4 RULE5
                    nxt_st.rvalid = 1'b0;
                    nxt_st.rlast  = 1'b0;
                    if (st_ff.rlast) begin
                        nxt_st.arready = 1'b1;
                        nxt_st.rd      = RD_IDLE;
                    end else begin
                        nxt_st.rptr  = st_ff.rptr + AW'(1);
                        nxt_st.rleft = st_ff.rleft - LEN_W'(1);
                        nxt_st.rd    = RD_BEAT;
                    end
                end
            end
            default: begin
                nxt_st.rd = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin  // RULE26
        if (i_srst) begin
            st_ff         <= '0;  // RULE25
            st_ff.awready <= 1'b1;
            st_ff.wready  <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.rd      <= RD_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // byte-lane writes of committed beats
    always_ff @(posedge i_clk) begin
        if (commit) begin
            for (int b = 0; b < DATA_W / 8; b++) begin
                if (st_ff.wbuf_s[b]) begin
                    mem_ff[st_ff.aw_ptr][b*8 +: 8] <= st_ff.wbuf_d[b*8 +: 8];
                end
            end
        end
    end

    // outputs are flip-flop copies or constants; nothing combinational reaches a port
    assign o_awready = st_ff.awready;  // RULE2 RULE8
    assign o_wready  = st_ff.wready;   // RULE2
    assign o_bid     = st_ff.bid;
    assign o_bresp   = RESP_OKAY;
    assign o_bvalid  = st_ff.bvalid;   // RULE2
    assign o_arready = st_ff.arready;  // RULE2
    assign o_rid     = st_ff.rid;
    assign o_rdata   = st_ff.rdata;
    assign o_rresp   = RESP_OKAY;
    assign o_rlast   = st_ff.rlast;
    assign o_rvalid  = st_ff.rvalid;   // RULE2
endmodule // axi_sub_handshake

/* tb/axi_sub_handshake_asserts.sv */
/*
 Checker for the subordinate handshake block: holds, order, last marking.
 Assumes default widths; bound to every instance of the block.
*/
`timescale 1ns/100ps
module axi_sub_handshake_asserts (
    input wire logic                         i_clk,     // clock
    input wire logic                         i_srst,    // sync reset
    input wire logic [axi_hs_pkg::LEN_W-1:0] i_arlen,   // read beats-1
    input wire logic                         i_awvalid, // aw valid
    input wire logic                         o_awready, // aw ready
    input wire logic                         i_wlast,   // final beat
    input wire logic                         i_wvalid,  // w valid
    input wire logic                         o_wready,  // w ready
    input wire logic [3:0]                   o_bid,     // resp id
    input wire logic [1:0]                   o_bresp,   // resp code
    input wire logic                         o_bvalid,  // resp valid
    input wire logic                         i_bready,  // resp ready
    input wire logic                         i_arvalid, // ar valid
    input wire logic                         o_arready, // ar ready
    input wire logic [3:0]                   o_rid,     // read id
    input wire logic [31:0]                  o_rdata,   // read data
    input wire logic                         o_rlast,   // read last
    input wire logic                         o_rvalid,  // read valid
    input wire logic                         i_rready   // read ready
);
    import axi_hs_pkg::*;
    logic [LEN_W-1:0] rlen_ff, rcnt_ff;
    logic [3:0]       apend_ff, wpend_ff;
    wire aw_hs = i_awvalid && o_awready;
    wire b_hs  = o_bvalid && i_bready;
    wire ar_hs = i_arvalid && o_arready;
    wire r_hs  = o_rvalid && i_rready;
    // pending counts tell whether a response has anything to answer
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            {rlen_ff, rcnt_ff, apend_ff, wpend_ff} <= '0;
        end else begin
            apend_ff <= apend_ff + 4'(aw_hs) - 4'(b_hs);
            wpend_ff <= wpend_ff + 4'(i_wvalid && o_wready && i_wlast) - 4'(b_hs);
            rlen_ff  <= ar_hs ? i_arlen : rlen_ff;
            rcnt_ff  <= ar_hs ? '0 : rcnt_ff + LEN_W'(r_hs);
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence ar_hs_s;
        i_arvalid && o_arready;
    endsequence
    sequence r_first_s;
        ##2 o_rvalid;
    endsequence
    rst_idle_a: assert property (disable iff (1'b0) $fell(i_srst) |->
        o_awready && o_wready && o_arready && !o_bvalid && !o_rvalid)
        else $error("ready or valid wrong after reset");
    ar_resp_a: assert property (ar_hs_s |-> r_first_s)
        else $error("read data not two cycles after address");
    rd_order_a: assert property ($rose(o_rvalid) |-> $past(ar_hs, 2) || $past(r_hs, 2))
        else $error("read valid without a request");
    rlast_cnt_a: assert property (o_rvalid |-> o_rlast == (rcnt_ff == rlen_ff))
        else $error("read last on wrong beat");
    bvalid_hold_a: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable({o_bid, o_bresp}))
        else $error("response dropped or changed");
    rvalid_hold_a: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable({o_rid, o_rdata, o_rlast}))
        else $error("read beat dropped or changed");
    wr_last_a: assert property ($rose(o_bvalid) |-> wpend_ff != '0)
        else $error("response before last beat");
    wr_addr_a: assert property ($rose(o_bvalid) |-> apend_ff != '0)
        else $error("response before address");
    w_park_a: assert property (i_wvalid && o_wready |=> !o_wready)
        else $error("write ready not parked after beat");
endmodule // axi_sub_handshake_asserts

bind axi_sub_handshake axi_sub_handshake_asserts u_chk (.i_clk, .i_srst, .i_arlen,
    .i_awvalid, .o_awready, .i_wlast, .i_wvalid, .o_wready, .o_bid, .o_bresp, .o_bvalid,
    .i_bready, .i_arvalid, .o_arready, .o_rid, .o_rdata, .o_rlast, .o_rvalid, .i_rready);

/* tb/axi_master_model.sv */
/*
 Requester model: write and read burst tasks with adjustable stalls.
 Assumes one task at a time, called only after reset is released.
*/
`timescale 1ns/100ps
module axi_master_model (
    input  wire logic        i_clk,     // clock
    output logic [3:0]       o_awid,    // write id
    output logic [31:0]      o_awaddr,  // write address
    output logic [7:0]       o_awlen,   // beats-1
    output logic             o_awvalid, // aw valid
    input  wire logic        i_awready, // aw ready
    output logic [31:0]      o_wdata,   // write data
    output logic [3:0]       o_wstrb,   // strobes
    output logic             o_wlast,   // final beat
    output logic             o_wvalid,  // w valid
    input  wire logic        i_wready,  // w ready
    input  wire logic [3:0]  i_bid,     // resp id
    input  wire logic        i_bvalid,  // resp valid
    output logic             o_bready,  // resp ready
    output logic [3:0]       o_arid,    // read id
    output logic [31:0]      o_araddr,  // read address
    output logic [7:0]       o_arlen,   // beats-1
    output logic             o_arvalid, // ar valid
    input  wire logic        i_arready, // ar ready
    input  wire logic [3:0]  i_rid,     // read id
    input  wire logic [31:0] i_rdata,   // read data
    input  wire logic        i_rlast,   // read last
    input  wire logic        i_rvalid,  // read valid
    output logic             o_rready   // read ready
);
    int          tmo = 0;
    logic [31:0] rbuf [16];
    logic        rlst [16];
    logic [3:0]  got_bid, got_rid;
    wire  [4:0]  hs = {i_rvalid, i_arready, i_bvalid, i_wready, i_awready};
    initial begin
        {o_awid, o_awaddr, o_awlen, o_awvalid, o_wdata, o_wstrb, o_wlast, o_wvalid} = '0;
        {o_bready, o_arid, o_araddr, o_arlen, o_arvalid, o_rready} = '0;
    end
    task automatic wt(input int k);
        int n = 0;
        do
            @(posedge i_clk);
        while (!hs[k] && ++n < 40);
        if (n >= 40)
            tmo++;
    endtask
    task automatic wr(input logic [3:0] id, input logic [31:0] a, d,
                      input logic [7:0] len, input int adly, bst);
        @(posedge i_clk);
        fork
            begin
                repeat (adly) @(posedge i_clk);
                #1 {o_awid, o_awaddr, o_awlen, o_awvalid} = {id, a, len, 1'b1};
                wt(0);
                #1 {o_awvalid, o_awaddr} = {1'b0, ~a};
            end
            begin
                for (int i = 0; i <= len; i++) begin
                    #1 {o_wdata, o_wstrb, o_wlast, o_wvalid} = {d + i, 4'hF, i == len, 1'b1};
                    wt(1);
                end
                #1 {o_wvalid, o_wdata} = {1'b0, ~o_wdata};
            end
        join
        // waits for the response before readying, then stalls bst cycles
        wt(2);
        repeat (bst) @(posedge i_clk);
        #1 o_bready = 1'b1;
        @(posedge i_clk);
        got_bid = i_bid;
        #1 o_bready = 1'b0;
    endtask
    task automatic rd(input logic [3:0] id, input logic [31:0] a,
                      input logic [7:0] len, input int st);
        @(posedge i_clk);
        #1 {o_arid, o_araddr, o_arlen, o_arvalid} = {id, a, len, 1'b1};
        wt(3);
        #1 {o_arvalid, o_araddr} = {1'b0, ~a};
        for (int i = 0; i <= len; i++) begin
            wt(4);
            repeat (st) @(posedge i_clk);
            #1 o_rready = 1'b1;
            @(posedge i_clk);
            rbuf[i[3:0]] = i_rdata;
            rlst[i[3:0]] = i_rlast;
            got_rid = i_rid;
            #1 o_rready = 1'b0;
        end
    endtask
endmodule // axi_master_model

/* tb/tb_axi_channel_handshake.sv */
/*
 Self-checking bench: requester model drives the block through bursts.
 Assumes default parameters: 4-bit ids, 32-bit data, 16-word memory.
*/
`timescale 1ns/100ps
module tb_axi_channel_handshake;
    import axi_hs_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic [3:0]  i_awid, i_arid, o_bid, o_rid, i_wstrb;
    logic [31:0] i_awaddr, i_araddr, i_wdata, o_rdata;
    logic [7:0]  i_awlen, i_arlen;
    logic [1:0]  o_bresp, o_rresp;
    logic        i_awvalid, o_awready, i_wlast, i_wvalid, o_wready, o_bvalid, i_bready;
    logic        i_arvalid, o_arready, o_rlast, o_rvalid, i_rready;
    int          failures = 0;
    int          checks = 0;
    axi_sub_handshake dut (.i_clk, .i_srst, .i_awid, .i_awaddr, .i_awlen, .i_awvalid,
        .o_awready, .i_wdata, .i_wstrb, .i_wlast, .i_wvalid, .o_wready, .o_bid, .o_bresp,
        .o_bvalid, .i_bready, .i_arid, .i_araddr, .i_arlen, .i_arvalid, .o_arready,
        .o_rid, .o_rdata, .o_rresp, .o_rlast, .o_rvalid, .i_rready);
    axi_master_model mst (.i_clk, .o_awid(i_awid), .o_awaddr(i_awaddr), .o_awlen(i_awlen),
        .o_awvalid(i_awvalid), .i_awready(o_awready), .o_wdata(i_wdata), .o_wstrb(i_wstrb),
        .o_wlast(i_wlast), .o_wvalid(i_wvalid), .i_wready(o_wready), .i_bid(o_bid),
        .i_bvalid(o_bvalid), .o_bready(i_bready), .o_arid(i_arid), .o_araddr(i_araddr),
        .o_arlen(i_arlen), .o_arvalid(i_arvalid), .i_arready(o_arready), .i_rid(o_rid),
        .i_rdata(o_rdata), .i_rlast(o_rlast), .i_rvalid(o_rvalid), .o_rready(i_rready));
    initial forever #10 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        failures += mst.tmo;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_reset_idle;
        chk({o_awready, o_wready, o_arready}, 3'b111);
        chk({o_bvalid, o_rvalid, o_rlast}, 3'b000);
    endtask
    // data three cycles ahead of its address must still be answered
    task automatic t_data_first;
        mst.wr(4'h9, 32'h4, 32'h5A5A_0001, 8'h00, 3, 0);
        chk(mst.got_bid, 4'h9);
        mst.rd(4'h2, 32'h4, 8'h00, 0);
        chk(mst.rbuf[0], 32'h5A5A_0001);
        chk(mst.rlst[0], 1'b1);
    endtask
    // burst over the top word wraps; slow readers exercise the holds
    task automatic t_wrap_burst;
        mst.wr(4'h5, 32'h38, 32'hA000, 8'h03, 0, 2);
        chk(mst.got_bid, 4'h5);
        chk(o_bresp, RESP_OKAY);
        mst.rd(4'h6, 32'h38, 8'h03, 2);
        chk(mst.got_rid, 4'h6);
        chk(o_rresp, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            chk(mst.rbuf[i], 32'hA000 + i);
            chk(mst.rlst[i], i == 3);
        end
    endtask
    task automatic t_full_mem;
        mst.wr(4'hF, 32'h0, 32'hC0DE_0000, 8'h0F, 0, 0);
        mst.rd(4'h0, 32'h0, 8'h0F, 0);
        for (int i = 0; i < 16; i++)
            chk(mst.rbuf[i], 32'hC0DE_0000 + i);
        chk({mst.rlst[14], mst.rlst[15]}, 2'b01);
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_srst = 1'b0;
        @(posedge i_clk);
        #1 t_reset_idle();
        t_data_first();
        t_wrap_burst();
        t_full_mem();
        results();
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        failures++;
        results();
    end
endmodule // tb_axi_channel_handshake
